//--- cfs_core_regs.sv
// Core condition flags, stack pointer and context save sequencer
//
// How it works
// [RULE1] Add sets half carry on bit3 carry
// [RULE2] Negative flag copies result bit 7
// [RULE3] Zero flag set when result is zero
// [RULE4] Carry flag shows arithmetic overflow or underflow
// [RULE5] Carry set/cleared by commands, shifts, bit tests
// [RULE6] Bits 5,3 encode priority level code
// [RULE7] Interrupt entry loads priority from vector input
// [RULE8] Priority bits changed by enable/disable/return/halt/wait/pop
// [RULE9] Condition flags pushed and popped whole
// [RULE10] Pointer decrements after push, increments before pop
// [RULE11] Upper nine pointer bits fixed, low seven vary
// [RULE12] Reset or reset command loads 017Fh
// [RULE13] Pointer wraps silently at both limits
// [RULE14] Interrupt writes program counter low first
// [RULE15] Call uses two bytes, interrupt five
// [RULE16] Second index register never auto-saved
// [RULE17] Pointer low byte loadable and readable
// [RULE18] Sixteen-bit program counter from two bytes
// [RULE19] Push PROGRAM_COUNTER_LOW,PROGRAM_COUNTER_HIGH,X,A,CC; return pops reverse
`timescale 1ns/1ps
`include "cfs_defs.svh"

module cfs_core_regs
    import cfs_pkg::*;
#(
    parameter int STACK_DEPTH = 128
) (
    // Clock and reset
    input wire logic clk_in,
    input wire logic rst_n_in,
    // Operation request from the decoder
    input wire logic op_valid_in,
    input wire cfs_op_t op_in,
    input wire cfs_sel_t reg_sel_in,
    input wire logic [7:0] operand_in,
    input wire logic ext_carry_in,
    input wire logic [1:0] vec_prio_in,
    input wire logic [15:0] target_pc_in,
    // Stack memory port
    input wire logic [7:0] mem_rdata_in,
    output logic [15:0] mem_addr_out,
    output logic [7:0] mem_wdata_out,
    output logic mem_we_out,
    output logic mem_re_out,
    // Register state
    output logic busy_out,
    output logic [7:0] cc_out,
    output logic [15:0] sp_out,
    output logic [15:0] pc_out,
    output logic [7:0] acc_out,
    output logic [7:0] x_out,
    output logic [7:0] y_out
);

    // Only a 128-byte stack with nine fixed upper bits is supported
    if (STACK_DEPTH != 128) begin : g_depth_check
        $error("cfs_core_regs: STACK_DEPTH must be 128");
    end

    // ----------------------------------------------------------------
    // State
    // ----------------------------------------------------------------
    cfs_state_t state_reg, state_next;
    logic [2:0] cnt_reg, cnt_next;
    logic [2:0] len_reg, len_next;
    logic is_int_reg, is_int_next;
    logic [1:0] prio_reg, prio_next;
    logic [15:0] tgt_reg, tgt_next;
    logic [7:0] cc_reg, cc_next;
    logic [6:0] sp_reg, sp_next;
    logic [15:0] pc_reg, pc_next;
    logic [7:0] acc_reg, acc_next;
    logic [7:0] x_reg, x_next;
    logic [7:0] y_reg, y_next;

    logic take;
    logic [8:0] sum9;
    logic [4:0] half5;
    logic [7:0] result;
    logic [6:0] sp_up;
    logic [6:0] sp_down;
    logic [2:0] ctx_idx;
    logic [7:0] ctx_byte;
    logic [7:0] sel_byte;

    assign take = op_valid_in && (state_reg == CFS_ST_IDLE);
    assign sp_up = sp_reg + 7'h01; // [RULE13]
    assign sp_down = sp_reg - 7'h01; // [RULE13]
    assign sum9 = {1'b0, acc_reg} + {1'b0, operand_in}
                  + {8'h00, (op_in == CFS_OP_ADC) && cc_reg[`CFS_BIT_CARRY]};
    assign half5 = {1'b0, acc_reg[3:0]} + {1'b0, operand_in[3:0]}
                   + {4'h0, (op_in == CFS_OP_ADC) && cc_reg[`CFS_BIT_CARRY]};

    // Interrupt contexts run forward on push and backward on pop;
    // a call uses only the first two entries
    always_comb begin
        if (state_reg == CFS_ST_PUSH) begin
            ctx_idx = cnt_reg; // [RULE19]
        end else begin
            ctx_idx = len_reg - 3'h1 - cnt_reg; // [RULE19]
        end
    end

    always_comb begin
        unique case (ctx_idx)
            `CFS_CTX_PCL: ctx_byte = pc_reg[7:0];
            `CFS_CTX_PCH: ctx_byte = pc_reg[15:8];
            `CFS_CTX_X: ctx_byte = x_reg;
            `CFS_CTX_A: ctx_byte = acc_reg;
            default: ctx_byte = cc_reg;
        endcase
    end

    always_comb begin
        unique case (reg_sel_in)
            CFS_SEL_ACC: sel_byte = acc_reg;
            CFS_SEL_X: sel_byte = x_reg;
            CFS_SEL_Y: sel_byte = y_reg;
            CFS_SEL_CC: sel_byte = cc_reg;
        endcase
    end

    // ----------------------------------------------------------------
    // Next state
    // ----------------------------------------------------------------
    always_comb begin
        state_next = state_reg;
        cnt_next = cnt_reg;
        len_next = len_reg;
        is_int_next = is_int_reg;
        prio_next = prio_reg;
        tgt_next = tgt_reg;
        cc_next = cc_reg;
        sp_next = sp_reg;
        pc_next = pc_reg;
        acc_next = acc_reg;
        x_next = x_reg;
        y_next = y_reg;
        result = operand_in;
        mem_addr_out = {`CFS_SP_HIGH_FIXED, sp_reg};
        mem_wdata_out = 8'h00;
        mem_we_out = 1'b0;
        mem_re_out = 1'b0;
        unique case (state_reg)
            CFS_ST_IDLE: begin
                if (take) begin
                    unique case (op_in)
                        CFS_OP_ADD, CFS_OP_ADC: begin
                            result = sum9[7:0];
                            acc_next = result;
                            cc_next[`CFS_BIT_HALF] = half5[4]; // [RULE1]
                            cc_next[`CFS_BIT_CARRY] = sum9[8]; // [RULE4]
                        end
                        CFS_OP_SUB: begin
                            result = acc_reg - operand_in;
                            acc_next = result;
                            cc_next[`CFS_BIT_CARRY] = acc_reg < operand_in; // [RULE4]
                        end
                        CFS_OP_LOGIC: begin
                            acc_next = result;
                        end
                        CFS_OP_SHIFT: begin
                            acc_next = result;
                            cc_next[`CFS_BIT_CARRY] = ext_carry_in; // [RULE5]
                        end
                        CFS_OP_BIT_TEST: begin
                            cc_next[`CFS_BIT_CARRY] = ext_carry_in; // [RULE5]
                        end
                        CFS_OP_SET_CARRY: begin
                            cc_next[`CFS_BIT_CARRY] = 1'b1; // [RULE5]
                        end
                        CFS_OP_CLEAR_CARRY: begin
                            cc_next[`CFS_BIT_CARRY] = 1'b0; // [RULE5]
                        end
                        CFS_OP_INT_ENABLE, CFS_OP_HALT, CFS_OP_WAIT_INT: begin
                            // Halt and wait re-open interrupts so the core can wake
                            cc_next[`CFS_BIT_PRIO_HIGH] = 1'b1; // [RULE8]
                            cc_next[`CFS_BIT_PRIO_LOW] = 1'b0; // [RULE6]
                        end
                        CFS_OP_INT_DISABLE: begin
                            cc_next[`CFS_BIT_PRIO_HIGH] = 1'b1; // [RULE8]
                            cc_next[`CFS_BIT_PRIO_LOW] = 1'b1; // [RULE6]
                        end
                        CFS_OP_LOAD_REG: begin
                            unique case (reg_sel_in)
                                CFS_SEL_ACC: acc_next = operand_in;
                                CFS_SEL_X: x_next = operand_in;
                                CFS_SEL_Y: y_next = operand_in;
                                CFS_SEL_CC: cc_next = operand_in;
                            endcase
                        end
                        CFS_OP_PUSH: begin
                            mem_we_out = 1'b1;
                            mem_wdata_out = sel_byte; // [RULE9]
                            sp_next = sp_down; // [RULE10]
                        end
                        CFS_OP_POP: begin
                            mem_re_out = 1'b1;
                            mem_addr_out = {`CFS_SP_HIGH_FIXED, sp_up}; // [RULE10]
                            sp_next = sp_up;
                            unique case (reg_sel_in)
                                CFS_SEL_ACC: acc_next = mem_rdata_in;
                                CFS_SEL_X: x_next = mem_rdata_in;
                                CFS_SEL_Y: y_next = mem_rdata_in;
                                CFS_SEL_CC: cc_next = mem_rdata_in; // [RULE9]
                            endcase
                        end
                        CFS_OP_LOAD_SP: begin
                            sp_next = operand_in[6:0]; // [RULE17]
                        end
                        CFS_OP_RESET_SP: begin
                            sp_next = `CFS_SP_RESET_LOW; // [RULE12]
                        end
                        CFS_OP_JUMP: begin
                            pc_next = target_pc_in; // [RULE18]
                        end
                        CFS_OP_CALL, CFS_OP_INT: begin
                            state_next = CFS_ST_PUSH;
                            cnt_next = 3'h0;
                            is_int_next = op_in == CFS_OP_INT;
                            len_next = (op_in == CFS_OP_INT) ? `CFS_INT_BYTES
                                                            : `CFS_CALL_BYTES; // [RULE15]
                            prio_next = vec_prio_in;
                            tgt_next = target_pc_in;
                        end
                        CFS_OP_RET, CFS_OP_INT_RETURN: begin
                            state_next = CFS_ST_POP;
                            cnt_next = 3'h0;
                            is_int_next = op_in == CFS_OP_INT_RETURN;
                            len_next = (op_in == CFS_OP_INT_RETURN) ? `CFS_INT_BYTES
                                                                   : `CFS_CALL_BYTES;
                        end
                        default: begin
                        end
                    endcase
                    if (op_in inside {CFS_OP_ADD, CFS_OP_ADC, CFS_OP_SUB,
                                      CFS_OP_LOGIC, CFS_OP_SHIFT}) begin
                        cc_next[`CFS_BIT_NEG] = result[7]; // [RULE2]
                        cc_next[`CFS_BIT_ZERO] = result == 8'h00; // [RULE3]
                    end
                end
            end
            CFS_ST_PUSH: begin
                // Context bytes go to successively lower addresses
                mem_we_out = 1'b1;
                mem_wdata_out = ctx_byte; // [RULE14]
                sp_next = sp_down; // [RULE10]
                cnt_next = cnt_reg + 3'h1;
                if (cnt_reg == len_reg - 3'h1) begin
                    state_next = CFS_ST_IDLE;
                    pc_next = tgt_reg;
                    if (is_int_reg) begin
                        // Loaded on the same edge that pushes the old flags to the stack
                        cc_next[`CFS_BIT_PRIO_HIGH] = prio_reg[1]; // [RULE7]
                        cc_next[`CFS_BIT_PRIO_LOW] = prio_reg[0]; // [RULE7]
                    end
                end
            end
            CFS_ST_POP: begin
                mem_re_out = 1'b1;
                mem_addr_out = {`CFS_SP_HIGH_FIXED, sp_up};
                sp_next = sp_up; // [RULE10]
                cnt_next = cnt_reg + 3'h1;
                // The second index register is not part of any context
                unique case (ctx_idx)
                    `CFS_CTX_PCL: pc_next[7:0] = mem_rdata_in;
                    `CFS_CTX_PCH: pc_next[15:8] = mem_rdata_in;
                    `CFS_CTX_X: x_next = mem_rdata_in; // [RULE16]
                    `CFS_CTX_A: acc_next = mem_rdata_in;
                    default: cc_next = mem_rdata_in; // [RULE8]
                endcase
                if (cnt_reg == len_reg - 3'h1) begin
                    state_next = CFS_ST_IDLE;
                end
            end
        endcase
    end

    // ----------------------------------------------------------------
    // Registers
    // ----------------------------------------------------------------
    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
            state_reg <= CFS_ST_IDLE;
            cnt_reg <= 3'h0;
            len_reg <= 3'h0;
            is_int_reg <= 1'b0;
            prio_reg <= 2'h0;
            tgt_reg <= 16'h0000;
            cc_reg <= `CFS_CC_RESET;
            sp_reg <= `CFS_SP_RESET_LOW; // [RULE12]
            pc_reg <= 16'h0000;
            acc_reg <= 8'h00;
            x_reg <= 8'h00;
            y_reg <= 8'h00;
        end else begin
            state_reg <= state_next;
            cnt_reg <= cnt_next;
            len_reg <= len_next;
            is_int_reg <= is_int_next;
            prio_reg <= prio_next;
            tgt_reg <= tgt_next;
            cc_reg <= cc_next;
            sp_reg <= sp_next;
            pc_reg <= pc_next;
            acc_reg <= acc_next;
            x_reg <= x_next;
            y_reg <= y_next;
        end
    end

    assign busy_out = state_reg != CFS_ST_IDLE;
    assign cc_out = cc_reg; // [RULE6]
    assign sp_out = {`CFS_SP_HIGH_FIXED, sp_reg}; // [RULE11]
    assign pc_out = pc_reg;
    assign acc_out = acc_reg;
    assign x_out = x_reg;
    assign y_out = y_reg;

    // ----------------------------------------------------------------
    // Assertions
    // ----------------------------------------------------------------
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (!rst_n_in);

    sequence s_int_start;
        take && op_in == CFS_OP_INT;
    endsequence
    sequence s_call_start;
        take && op_in == CFS_OP_CALL;
    endsequence

    a_sp_high_fixed: assert property (sp_out[15:7] == 9'h002) // [RULE11]
        else $error("stack pointer upper bits not fixed");
    a_sp_reset_cmd: assert property (take && op_in == CFS_OP_RESET_SP // [RULE12]
        |=> sp_out == 16'h017f)
        else $error("reset stack command did not load 017f");
    a_push_dec: assert property (mem_we_out |=> sp_reg == 7'($past(sp_reg) - 7'h01)) // [RULE10]
        else $error("pointer did not decrement after push");
    a_pop_preinc: assert property (mem_re_out // [RULE13]
        |-> mem_addr_out[6:0] == 7'(sp_reg + 7'h01) ##1 sp_reg == $past(mem_addr_out[6:0]))
        else $error("pop address not pre-incremented");
    a_int_five: assert property (s_int_start // [RULE15]
        |=> (mem_we_out && busy_out) [*5] ##1 !busy_out)
        else $error("interrupt did not push five bytes");
    a_call_two: assert property (s_call_start // [RULE15]
        |=> (mem_we_out && busy_out) [*2] ##1 !busy_out)
        else $error("call did not push two bytes");
    a_int_pcl_first: assert property (s_int_start // [RULE14]
        |=> mem_wdata_out == $past(pc_reg[7:0]) && mem_addr_out[6:0] == $past(sp_reg))
        else $error("interrupt did not push pc low first");
    a_int_prio_load: assert property (s_int_start // [RULE7]
        |-> ##6 {cc_reg[5], cc_reg[3]} == $past(vec_prio_in, 6))
        else $error("priority bits not loaded on interrupt entry");
    a_y_untouched: assert property (s_int_start |=> $stable(y_reg) [*5]) // [RULE16]
        else $error("second index register changed by interrupt");
    a_half_carry: assert property (take && op_in == CFS_OP_ADD // [RULE1]
        |=> cc_reg[4] == (5'($past(acc_reg[3:0])) + 5'($past(operand_in[3:0])) > 5'h0f))
        else $error("half carry wrong after add");
    a_zero_neg: assert property (take && op_in inside {CFS_OP_ADD, CFS_OP_LOGIC} // [RULE3]
        |=> cc_reg[1] == (acc_reg == 8'h00) && cc_reg[2] == acc_reg[7])
        else $error("zero or negative flag wrong");
    a_set_carry: assert property (take && op_in == CFS_OP_SET_CARRY |=> cc_reg[0]) // [RULE5]
        else $error("set carry command failed");
endmodule

//--- cfs_core_regs_test.sv
// Self-checking testbench for the core flags and stack pointer register block
`timescale 1ns/1ps
module cfs_core_regs_test import cfs_pkg::*;;

// ----------------------------------------
// Signals and stack memory
// ----------------------------------------
logic clk_in = 1'b0;
logic rst_n_in = 1'b0;
logic op_valid_in = 1'b0;
cfs_op_t op_in = CFS_OP_NOP;
cfs_sel_t reg_sel_in = CFS_SEL_ACC;
logic [7:0] operand_in = 8'h00;
logic ext_carry_in = 1'b0;
logic [1:0] vec_prio_in = 2'h0;
logic [15:0] target_pc_in = 16'h0000;
logic [7:0] mem_rdata_in;
logic [15:0] mem_addr_out;
logic [7:0] mem_wdata_out;
logic mem_we_out;
logic mem_re_out;
logic busy_out;
logic [7:0] cc_out;
logic [15:0] sp_out;
logic [15:0] pc_out;
logic [7:0] acc_out;
logic [7:0] x_out;
logic [7:0] y_out;
logic [7:0] mem [0:127];
logic [15:0] wa_q[$];
logic [7:0] wd_q[$];
logic c_in = 1'b0;
logic [1:0] p_in = 2'h0;
logic [15:0] t_pc = 16'h0000;
int errors = 0;
int check_count = 0;

always #10 clk_in = ~clk_in;

// Read is asynchronous, so the memory answers in the cycle of the strobe
assign mem_rdata_in = mem[mem_addr_out[6:0]];

always @(posedge clk_in) begin
    if (mem_we_out === 1'b1) begin
        mem[mem_addr_out[6:0]] <= mem_wdata_out;
        wa_q.push_back(mem_addr_out);
        wd_q.push_back(mem_wdata_out);
    end
end

cfs_core_regs #(.STACK_DEPTH(128)) i_dut (
    .clk_in(clk_in), .rst_n_in(rst_n_in), .op_valid_in(op_valid_in), .op_in(op_in),
    .reg_sel_in(reg_sel_in), .operand_in(operand_in), .ext_carry_in(ext_carry_in),
    .vec_prio_in(vec_prio_in), .target_pc_in(target_pc_in), .mem_rdata_in(mem_rdata_in),
    .mem_addr_out(mem_addr_out), .mem_wdata_out(mem_wdata_out), .mem_we_out(mem_we_out),
    .mem_re_out(mem_re_out), .busy_out(busy_out), .cc_out(cc_out), .sp_out(sp_out),
    .pc_out(pc_out), .acc_out(acc_out), .x_out(x_out), .y_out(y_out)
);

// ----------------------------------------
// Shared tasks
// ----------------------------------------
task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    check_count++;
    if (seen !== exp) begin
        errors++;
        $display("[ERR] t=%0t seen=%h expected=%h", $time, seen, exp);
    end
endtask

function automatic logic [7:0] mk_cc(input logic [1:0] p, input logic [3:0] f);
    return {2'b11, p[1], f[3], p[0], f[2:0]};
endfunction

// One request; waits out a multi-byte sequence under a bounded count
task automatic run_op(input cfs_op_t op, input cfs_sel_t sel, input logic [7:0] val);
    int n;
    @(posedge clk_in);
    op_valid_in <= 1'b1;
    op_in <= op;
    reg_sel_in <= sel;
    operand_in <= val;
    ext_carry_in <= c_in;
    vec_prio_in <= p_in;
    target_pc_in <= t_pc;
    @(posedge clk_in);
    op_valid_in <= 1'b0;
    #1;
    n = 0;
    while (busy_out !== 1'b0 && n < 20) begin
        @(posedge clk_in);
        #1;
        n++;
    end
    check(busy_out, 16'h0000);
endtask

task automatic end_sim();
    $display("checks=%0d mismatches=%0d", check_count, errors);
    if (errors == 0 && check_count > 0) begin
        $display("verification passed");
    end else begin
        $display("verification failed");
    end
    $finish;
endtask

// ----------------------------------------
// Scenarios
// ----------------------------------------
task automatic t_reset();
    check(sp_out, 16'h017f);
    check(cc_out, 16'h00e8);
    check(pc_out, 16'h0000);
    check(busy_out, 16'h0000);
    $display("test reset done");
endtask

task automatic t_alu();
    run_op(CFS_OP_LOAD_REG, CFS_SEL_ACC, 8'h0f);
    run_op(CFS_OP_ADD, CFS_SEL_ACC, 8'h01);
    check(acc_out, 16'h0010);
    check(cc_out, mk_cc(2'h3, 4'h8));
    run_op(CFS_OP_ADD, CFS_SEL_ACC, 8'hf0);
    check(cc_out, mk_cc(2'h3, 4'h3));
    run_op(CFS_OP_ADC, CFS_SEL_ACC, 8'h0f);
    check(cc_out, mk_cc(2'h3, 4'h8));
    run_op(CFS_OP_SUB, CFS_SEL_ACC, 8'h20);
    check(acc_out, 16'h00f0);
    check(cc_out[2:0], 16'h0005);
    run_op(CFS_OP_LOGIC, CFS_SEL_ACC, 8'h00);
    check(cc_out[2:0], 16'h0003);
    c_in = 1'b1;
    run_op(CFS_OP_SHIFT, CFS_SEL_ACC, 8'h80);
    check(cc_out[2:0], 16'h0005);
    c_in = 1'b0;
    run_op(CFS_OP_BIT_TEST, CFS_SEL_ACC, 8'h00);
    check(cc_out[2:0], 16'h0004);
    run_op(CFS_OP_SET_CARRY, CFS_SEL_ACC, 8'h00);
    check(cc_out[2:0], 16'h0005);
    run_op(CFS_OP_CLEAR_CARRY, CFS_SEL_ACC, 8'h00);
    check(cc_out[2:0], 16'h0004);
    $display("test alu flags done");
endtask

task automatic t_prio();
    cfs_op_t ops [5];
    logic [1:0] pexp [5];
    ops = '{CFS_OP_INT_ENABLE, CFS_OP_INT_DISABLE, CFS_OP_HALT, CFS_OP_INT_DISABLE,
            CFS_OP_WAIT_INT};
    pexp = '{2'h2, 2'h3, 2'h2, 2'h3, 2'h2};
    for (int i = 0; i < 5; i++) begin
        run_op(ops[i], CFS_SEL_ACC, 8'h00);
        check({cc_out[5], cc_out[3]}, pexp[i]);
    end
    $display("test priority done");
endtask

task automatic t_stack();
    run_op(CFS_OP_RESET_SP, CFS_SEL_ACC, 8'h00);
    run_op(CFS_OP_LOAD_REG, CFS_SEL_ACC, 8'h3c);
    run_op(CFS_OP_PUSH, CFS_SEL_ACC, 8'h00);
    check(mem[7'h7f], 16'h003c);
    check(sp_out, 16'h017e);
    run_op(CFS_OP_POP, CFS_SEL_X, 8'h00);
    check(x_out, 16'h003c);
    check(sp_out, 16'h017f);
    run_op(CFS_OP_PUSH, CFS_SEL_CC, 8'h00);
    check(mem[7'h7f], mk_cc(2'h2, 4'hc));
    mem[7'h7f] = 8'hcd;
    run_op(CFS_OP_POP, CFS_SEL_CC, 8'h00);
    check(cc_out, 16'h00cd);
    // Popping at the top limit must fetch from the bottom limit
    mem[7'h00] = 8'h99;
    run_op(CFS_OP_POP, CFS_SEL_Y, 8'h00);
    check(y_out, 16'h0099);
    check(sp_out, 16'h0100);
    run_op(CFS_OP_PUSH, CFS_SEL_ACC, 8'h00);
    check(mem[7'h00], 16'h003c);
    check(sp_out, 16'h017f);
    run_op(CFS_OP_LOAD_SP, CFS_SEL_ACC, 8'hd5);
    check(sp_out, 16'h0155);
    run_op(CFS_OP_LOAD_REG, CFS_SEL_CC, 8'he4);
    check(cc_out, 16'h00e4);
    run_op(CFS_OP_RESET_SP, CFS_SEL_ACC, 8'h00);
    check(sp_out, 16'h017f);
    $display("test stack done");
endtask

task automatic t_call();
    t_pc = 16'h1234;
    run_op(CFS_OP_JUMP, CFS_SEL_ACC, 8'h00);
    check(pc_out, 16'h1234);
    wa_q.delete();
    wd_q.delete();
    t_pc = 16'habcd;
    run_op(CFS_OP_CALL, CFS_SEL_ACC, 8'h00);
    check(wa_q.size(), 16'h0002);
    check(wa_q[0], 16'h017f);
    check(wd_q[0], 16'h0034);
    check(wa_q[1], 16'h017e);
    check(wd_q[1], 16'h0012);
    check(sp_out, 16'h017d);
    check(pc_out, 16'habcd);
    run_op(CFS_OP_RET, CFS_SEL_ACC, 8'h00);
    check(pc_out, 16'h1234);
    check(sp_out, 16'h017f);
    $display("test call done");
endtask

task automatic t_int();
    logic [7:0] dexp [5];
    dexp = '{8'h34, 8'h12, 8'h5a, 8'ha5, 8'hec};
    mem[7'h00] = 8'hec;
    run_op(CFS_OP_POP, CFS_SEL_CC, 8'h00);
    run_op(CFS_OP_RESET_SP, CFS_SEL_ACC, 8'h00);
    run_op(CFS_OP_LOAD_REG, CFS_SEL_ACC, 8'ha5);
    run_op(CFS_OP_LOAD_REG, CFS_SEL_X, 8'h5a);
    run_op(CFS_OP_LOAD_REG, CFS_SEL_Y, 8'h77);
    wa_q.delete();
    wd_q.delete();
    p_in = 2'h1;
    t_pc = 16'h8000;
    run_op(CFS_OP_INT, CFS_SEL_ACC, 8'h00);
    check(wa_q.size(), 16'h0005);
    for (int i = 0; i < 5; i++) begin
        check(wa_q[i], 16'h017f - 16'(i));
        check(wd_q[i], dexp[i]);
    end
    check(sp_out, 16'h017a);
    check(pc_out, 16'h8000);
    check(cc_out, mk_cc(2'h1, 4'h4));
    check(y_out, 16'h0077);
    run_op(CFS_OP_LOAD_REG, CFS_SEL_ACC, 8'h00);
    run_op(CFS_OP_LOAD_REG, CFS_SEL_X, 8'h00);
    run_op(CFS_OP_LOAD_REG, CFS_SEL_Y, 8'h11);
    run_op(CFS_OP_INT_RETURN, CFS_SEL_ACC, 8'h00);
    check(acc_out, 16'h00a5);
    check(x_out, 16'h005a);
    check(y_out, 16'h0011);
    check(pc_out, 16'h1234);
    check(cc_out, 16'h00ec);
    check(sp_out, 16'h017f);
    $display("test interrupt done");
endtask

// ----------------------------------------
// Main sequence and watchdog
// ----------------------------------------
initial begin
    for (int i = 0; i < 128; i++) begin
        mem[i] = 8'h00;
    end
    repeat (3) @(posedge clk_in);
    rst_n_in <= 1'b1;
    #1;
    t_reset();
    t_alu();
    t_prio();
    t_stack();
    t_call();
    t_int();
    end_sim();
end

// About 95 cycles are needed; the margin covers a stuck busy level
initial begin
    #100000;
    errors++;
    end_sim();
end

endmodule

//--- cfs_defs.svh
// Constants for the core flags and stack pointer register block
`ifndef CFS_DEFS_SVH
`define CFS_DEFS_SVH

// Condition code bit positions
`define CFS_BIT_CARRY 0
`define CFS_BIT_ZERO 1
`define CFS_BIT_NEG 2
`define CFS_BIT_PRIO_LOW 3
`define CFS_BIT_HALF 4
`define CFS_BIT_PRIO_HIGH 5
`define CFS_CC_RESET 8'he8

// Priority level codes {priority_bit_high, priority_bit_low}
`define CFS_PRIO_LEVEL0 2'h2
`define CFS_PRIO_LEVEL3 2'h3

// Stack pointer layout
`define CFS_SP_HIGH_FIXED 9'h002
`define CFS_SP_RESET_LOW 7'h7f
`define CFS_SP_RESET_VAL 16'h017f

// Context sizes in stack bytes
`define CFS_INT_BYTES 3'h5
`define CFS_CALL_BYTES 3'h2

// Context byte indices
`define CFS_CTX_PCL 3'h0
`define CFS_CTX_PCH 3'h1
`define CFS_CTX_X 3'h2
`define CFS_CTX_A 3'h3
`define CFS_CTX_CC 3'h4

`endif

//--- cfs_pkg.sv
// Types for the core flags and stack pointer register block
package cfs_pkg;

    typedef enum logic [4:0] {
        CFS_OP_NOP,
        CFS_OP_ADD,
        CFS_OP_ADC,
        CFS_OP_SUB,
        CFS_OP_LOGIC,
        CFS_OP_SHIFT,
        CFS_OP_BIT_TEST,
        CFS_OP_SET_CARRY,
        CFS_OP_CLEAR_CARRY,
        CFS_OP_INT_ENABLE,
        CFS_OP_INT_DISABLE,
        CFS_OP_HALT,
        CFS_OP_WAIT_INT,
        CFS_OP_LOAD_REG,
        CFS_OP_PUSH,
        CFS_OP_POP,
        CFS_OP_LOAD_SP,
        CFS_OP_RESET_SP,
        CFS_OP_JUMP,
        CFS_OP_CALL,
        CFS_OP_RET,
        CFS_OP_INT,
        CFS_OP_INT_RETURN
    } cfs_op_t;

    typedef enum logic [1:0] {
        CFS_SEL_ACC,
        CFS_SEL_X,
        CFS_SEL_Y,
        CFS_SEL_CC
    } cfs_sel_t;

    typedef enum {
        CFS_ST_IDLE,
        CFS_ST_PUSH,
        CFS_ST_POP
    } cfs_state_t;

endpackage
